// ===== dv/isag_fetch_model.sv
// index word fetch model, at most one word a cycle
`timescale 1ns/1ps
module isag_fetch_model (
  // control
  input  wire        clk_in, start_in, busy_in, slow_in,
  input  wire [1:0]  count_in,
  // words
  input  wire [15:0] word0_in, word1_in,
  output reg         valid_out = 0,
  output reg  [15:0] word_out = 0
);
  integer k = 0;
  reg skip = 0;
  // word0 always first; slow mode leaves a gap every other cycle
  always @(posedge clk_in) begin
    skip <= ~skip;
    if (start_in && !busy_in) k = 0;
    if ((start_in || busy_in) && k < count_in && !(slow_in && skip)) begin
      valid_out <= 1'b1;
      word_out <= k ? word1_in : word0_in;
      k = k + 1;
    end else begin
      valid_out <= 1'b0;
      word_out <= ~word_out; // idle bus flips the released word each cycle
    end
  end
endmodule // isag_fetch_model

// ===== dv/isag_properties.sv
// port assertions for the address generator
`timescale 1ns/1ps
module isag_checker (
  input wire ref_clk_in, reset_in, start_in, dst_mode_in, index_valid_in,
  input wire busy_out, index_take_out, src_valid_out, dst_valid_out,
  input wire second_word_out, wide_data_out,
  input wire [1:0] source_mode_field_in,
  input wire [19:0] src_addr_out, dst_addr_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  start_busy_a: assert property (start_in && !busy_out &&
    (source_mode_field_in == 2'h1 || dst_mode_in) |=> busy_out) else $error("no busy");
  take_cause_a: assert property (index_take_out |->
    $past(index_valid_in && busy_out)) else $error("take without word");
  src_take_a: assert property (src_valid_out |-> index_take_out) else $error("src");
  dst_take_a: assert property (dst_valid_out |-> index_take_out) else $error("dst");
  src_pulse_a: assert property (src_valid_out |=> !src_valid_out) else $error("pulse");
  src_hold_a: assert property (!src_valid_out |-> $stable(src_addr_out)) else $error("s");
  dst_hold_a: assert property (!dst_valid_out |-> $stable(dst_addr_out)) else $error("d");
  wide_pair_a: assert property (second_word_out |-> wide_data_out) else $error("w");
  cover property (src_valid_out);
  cover property (dst_valid_out);
  cover property (second_word_out && dst_valid_out);
endmodule // isag_checker
bind isag_top isag_checker i_isag_checker (.ref_clk_in(ref_clk_in),
  .reset_in(reset_in), .start_in(start_in), .dst_mode_in(dst_mode_in),
  .index_valid_in(index_valid_in), .busy_out(busy_out),
  .index_take_out(index_take_out), .src_valid_out(src_valid_out),
  .dst_valid_out(dst_valid_out), .second_word_out(second_word_out),
  .wide_data_out(wide_data_out), .source_mode_field_in(source_mode_field_in),
  .src_addr_out(src_addr_out), .dst_addr_out(dst_addr_out));

// ===== dv/isag_tb_top.sv
// self-checking bench for the address generator
`timescale 1ns/1ps
module isag_tb_top;
  reg clk = 0, rst = 1, st = 0, dm = 0, sp = 0, dp = 0, lf = 0, bw = 0, sl = 0;
  reg [1:0] fm = 0, sm = 0, n = 0;
  reg [19:0] sb = 0, db = 0, pc = 0, es, ed;
  reg [3:0] sh = 0, dh = 0;
  reg [15:0] w0 = 0, w1 = 0;
  wire iv, bsy, tk, sv, dv, wd, sw;
  wire [15:0] iw;
  wire [19:0] sa, da;
  wire [1:0] nw;
  integer n_fail = 0, check_count = 0, cyc = 0, t, i, ns, nd;
  isag_top i_isag_top (.ref_clk_in(clk), .reset_in(rst), .start_in(st),
    .format_in(fm), .source_mode_field_in(sm), .dst_mode_in(dm),
    .src_is_pc_in(sp), .dst_is_pc_in(dp), .length_flag_in(lf),
    .byte_word_in(bw), .src_base_register_in(sb), .dst_base_register_in(db),
    .opcode_pc_in(pc), .src_index_hi_in(sh), .dst_index_hi_in(dh),
    .index_valid_in(iv), .index_word_in(iw), .busy_out(bsy),
    .index_take_out(tk), .src_valid_out(sv), .src_addr_out(sa),
    .dst_valid_out(dv), .dst_addr_out(da), .wide_data_out(wd),
    .second_word_out(sw), .index_words_out(nw));
  isag_fetch_model i_isag_fetch_model (.clk_in(clk), .start_in(st),
    .busy_in(bsy), .slow_in(sl), .count_in(n), .word0_in(w0),
    .word1_in(w1), .valid_out(iv), .word_out(iw));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc == 5000) begin n_fail++; conclude(); end
  function [19:0] ea(input [1:0] f, input [19:0] b, input [3:0] h,
                     input [15:0] x);
    if (f == 2'h1) ea = b + {h, x};
    else if (f == 2'h0 && b <= 20'h0ffff) ea = {4'h0, b[15:0] + x};
    else ea = b + {{4{x[15]}}, x};
  endfunction
  task check(input [19:0] got, input [19:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8bd5));
    repeat (4) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      // first bases straddle the 64KB boundary, then half stay low
      sb <= i < 4 ? 20'h0fffe + i : $urandom & (i[0] ? 20'hfffff : 20'h0ffff);
      db <= $urandom & (i[1] ? 20'hfffff : 20'h0ffff);
      pc <= $urandom & (i[2] ? 20'hffffe : 20'h0fffe);
      fm <= 2'(i % 3);
      {sm, dm, sp, dp, lf, bw, sl} <= 8'($urandom);
      {sh, dh, w0, w1} <= {$urandom, $urandom};
      @(posedge clk);
      n <= (sm == 2'h1) + dm;
      st <= 1;
      @(posedge clk);
      st <= 0;
      es = ea(fm, sp ? pc + 2 : sb, sh, w0);
      ed = ea(fm, dp ? pc + (sm == 1 ? 4 : 2) : db, dh, sm == 1 ? w1 : w0);
      ns = 0;
      nd = 0;
      for (t = 0; t < 12; t++) begin
        @(negedge clk);
        if (sv) begin ns++; check(sa, es); end
        if (dv) begin nd++; check(da, ed); end
        if (sv | dv) check(nw, n);
        if (sv | dv) check(tk, 1'b1);
        if (sv | dv) check(bsy, sv && dm);
        if (sv | dv) check({wd, sw}, {{lf, bw} == 2'h1 || fm == 2, fm == 2});
      end
      check(ns, sm == 2'h1);
      check(nd, dm);
      $display("test %0d done fails %0d", i, n_fail);
    end
    conclude();
  end
endmodule // isag_tb_top

// ===== logic/isag_adder.v
// combinational effective-address adder for one operand
`timescale 1ns/1ps
`include "isag_defs.vh"
module isag_adder #(
  parameter AW = 20,
  parameter DW = 16
) (
  // operands
  input  wire [1:0]    format_in,
  input  wire [AW-1:0] base_in,
  input  wire [3:0]    index_hi_in,
  input  wire [DW-1:0] index_lo_in,
  // result
  output reg  [AW-1:0] addr_out
);
  reg [AW-1:0] index_full;
  reg [AW-1:0] sum;
  always @* begin
    index_full = {{(AW-DW){index_lo_in[DW-1]}}, index_lo_in};
    if (format_in == `ISAG_FMT_EXT) begin
      index_full = {index_hi_in, index_lo_in};
    end
    // the sum wraps naturally at the 20-bit width
    sum = base_in + index_full;
    addr_out = sum;
    if (format_in == `ISAG_FMT_LEGACY && base_in <= `ISAG_LOW_LIMIT) begin
      addr_out = {`ISAG_HI_ZERO, sum[DW-1:0]};
    end
  end
endmodule // isag_adder

// ===== logic/isag_defs.vh
// constants for the indexed and symbolic address generator
`ifndef ISAG_DEFS_VH
`define ISAG_DEFS_VH
`define ISAG_AW          20
`define ISAG_DW          16
`define ISAG_LOW_LIMIT   20'h0ffff
`define ISAG_HI_ZERO     4'h0
`define ISAG_WORD_STEP   20'h00002
`define ISAG_SRC_INDEXED 2'h1
`define ISAG_DST_INDEXED 1'h1
`define ISAG_AL_BW_ADDR  2'h1
`define ISAG_FMT_LEGACY  2'h0
`define ISAG_FMT_EXT     2'h1
`define ISAG_FMT_ADDR    2'h2
`endif

// ===== logic/isag_top.v
// indexed and symbolic operand address generator
//
// Behaviour
// - legacy low base: add, clear bits 19:16
// - low-base index follows opcode, stays 16-bit
// - legacy high base: sign-extend, 20-bit wrap
// - high base reaches about 32KB, may wrap
// - extended index: 4 bits extension, 16 following
// - base register never altered by sum
// - fetch consumes matching count of index words
// - address instructions: sign-extended index, two words
// - symbolic low pc: add, clear bits 19:16
// - pc unchanged; sum is temporary address only
// - symbolic high pc: sign-extend, 20-bit wrap
// - source and destination each get own index
// - symbolic is indexed with pc base
`timescale 1ns/1ps
`include "isag_defs.vh"
module isag_top #(
  parameter AW = 20,
  parameter DW = 16
) (
  // clock and reset
  input  wire          ref_clk_in,
  input  wire          reset_in,
  // decoder request
  input  wire          start_in,
  input  wire [1:0]    format_in,
  input  wire [1:0]    source_mode_field_in,
  input  wire          dst_mode_in,
  input  wire          src_is_pc_in,
  input  wire          dst_is_pc_in,
  input  wire          length_flag_in,
  input  wire          byte_word_in,
  input  wire [AW-1:0] src_base_register_in,
  input  wire [AW-1:0] dst_base_register_in,
  input  wire [AW-1:0] opcode_pc_in,
  input  wire [3:0]    src_index_hi_in,
  input  wire [3:0]    dst_index_hi_in,
  // index word stream from fetch
  input  wire          index_valid_in,
  input  wire [DW-1:0] index_word_in,
  // results
  output reg           busy_out,
  output reg           index_take_out,
  output reg           src_valid_out,
  output reg  [AW-1:0] src_addr_out,
  output reg           dst_valid_out,
  output reg  [AW-1:0] dst_addr_out,
  output reg           wide_data_out,
  output reg           second_word_out,
  output reg  [1:0]    index_words_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SRC  = 3'b010;
  localparam ST_DST  = 3'b100;

  reg [2:0]    state;
  reg [1:0]    fmt;
  reg          dst_idx;
  reg          src_pc;
  reg          dst_pc;
  reg [AW-1:0] src_base;
  reg [AW-1:0] dst_base;
  reg [3:0]    src_hi;
  reg [3:0]    dst_hi;
  reg [AW-1:0] word_pc;
  reg [AW-1:0] next_word_pc;
  reg [AW-1:0] cur_base;
  reg [3:0]    cur_hi;
  wire [AW-1:0] sum;

  // decoding shared by the request latch, the branch and the word count
  function src_indexed;
    input [1:0] mode;
    begin
      src_indexed = (mode == `ISAG_SRC_INDEXED);
    end
  endfunction

  function dst_indexed;
    input mode;
    begin
      dst_indexed = (mode == `ISAG_DST_INDEXED);
    end
  endfunction

  function [1:0] index_count;
    input [1:0] mode;
    input       dmode;
    begin
      index_count = {1'b0, src_indexed(mode)} + {1'b0, dst_indexed(dmode)};
    end
  endfunction

  function wide_data;
    input       length_flag;
    input       byte_word;
    input [1:0] format;
    begin
      // address instructions always move two-word operands
      wide_data = ({length_flag, byte_word} == `ISAG_AL_BW_ADDR) ||
                  (format == `ISAG_FMT_ADDR);
    end
  endfunction

  function [AW-1:0] word_after;
    input [AW-1:0] addr;
    begin
      word_after = addr + `ISAG_WORD_STEP;
    end
  endfunction

  function [AW-1:0] pick_base;
    input          use_pc;
    input [AW-1:0] pc;
    input [AW-1:0] base;
    begin
      pick_base = use_pc ? pc : base;
    end
  endfunction

  // base and pc are only read here, so the sum never rewrites either
  always @* begin
    cur_base = (state == ST_SRC) ? pick_base(src_pc, word_pc, src_base)
                                 : pick_base(dst_pc, word_pc, dst_base);
    cur_hi   = (state == ST_SRC) ? src_hi : dst_hi;
    next_word_pc = word_after(word_pc);
  end

  isag_adder #(
    .AW (AW),
    .DW (DW)
  ) u_adder (
    .format_in   (fmt),
    .base_in     (cur_base),
    .index_hi_in (cur_hi),
    .index_lo_in (index_word_in),
    .addr_out    (sum)
  );

  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      state           <= ST_IDLE;
      fmt             <= `ISAG_FMT_LEGACY;
      dst_idx         <= 1'b0;
      src_pc          <= 1'b0;
      dst_pc          <= 1'b0;
      src_base        <= {AW{1'b0}};
      dst_base        <= {AW{1'b0}};
      src_hi          <= `ISAG_HI_ZERO;
      dst_hi          <= `ISAG_HI_ZERO;
      word_pc         <= {AW{1'b0}};
      busy_out        <= 1'b0;
      index_take_out  <= 1'b0;
      src_valid_out   <= 1'b0;
      src_addr_out    <= {AW{1'b0}};
      dst_valid_out   <= 1'b0;
      dst_addr_out    <= {AW{1'b0}};
      wide_data_out   <= 1'b0;
      second_word_out <= 1'b0;
      index_words_out <= 2'h0;
    end else begin
      index_take_out <= 1'b0;
      src_valid_out  <= 1'b0;
      dst_valid_out  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_in) begin
            fmt      <= format_in;
            dst_idx  <= dst_indexed(dst_mode_in);
            src_pc   <= src_is_pc_in;
            dst_pc   <= dst_is_pc_in;
            src_base <= src_base_register_in;
            dst_base <= dst_base_register_in;
            src_hi   <= src_index_hi_in;
            dst_hi   <= dst_index_hi_in;
            // first index word sits right after the opcode word
            word_pc  <= word_after(opcode_pc_in);
            wide_data_out <= wide_data(length_flag_in, byte_word_in,
                                       format_in);
            second_word_out <= (format_in == `ISAG_FMT_ADDR);
            index_words_out <= index_count(source_mode_field_in,
                                           dst_mode_in);
            if (src_indexed(source_mode_field_in)) begin
              state    <= ST_SRC;
              busy_out <= 1'b1;
            end else if (dst_indexed(dst_mode_in)) begin
              state    <= ST_DST;
              busy_out <= 1'b1;
            end
          end
        end
        ST_SRC: begin
          // a word left standing would be taken again by the next state
          if (index_valid_in) begin
            index_take_out <= 1'b1;
            src_valid_out  <= 1'b1;
            src_addr_out   <= sum;
            word_pc        <= next_word_pc;
            if (dst_idx) begin
              state <= ST_DST;
            end else begin
              state    <= ST_IDLE;
              busy_out <= 1'b0;
            end
          end
        end
        ST_DST: begin
          if (index_valid_in) begin
            index_take_out <= 1'b1;
            dst_valid_out  <= 1'b1;
            dst_addr_out   <= sum;
            word_pc        <= next_word_pc;
            state          <= ST_IDLE;
            busy_out       <= 1'b0;
          end
        end
        default: begin
          state    <= ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end
endmodule // isag_top
